// ==== logic/mcs_cfg_if.sv ====
/*
  Decoded configuration carried from the configuration store to the
  macrocell datapath.
  Assumes both ends share sys_clk.
*/
`timescale 1ns/1ns
interface mcs_cfg_if;
  import mcs_pkg::*;
  mcs_mode_type                mode;
  logic [2*NUM_CELLS-1:0]      cell_cfg;
  modport store (output mode, output cell_cfg);
  modport cells (input mode, input cell_cfg);
endinterface

// ==== logic/mcs_config_security.sv ====
/*
  Top of the macrocell configuration and security block: array store,
  architecture cells, security cell, signature word, bulk erase and
  verify read-back, plus the macrocell datapath.
  Every command is taken on the edge that sees cmd_valid high; its
  answer (read data or a refusal) stands for the following cycle.
  Assumes the programming port is driven synchronously to sys_clk,
  one command per cycle at most; the dedicated pins arrive
  asynchronously. The array store has no reset, so the programmer
  must erase before the first array verify.
*/
`timescale 1ns/1ns
// Notes on behaviour
// - Once secured, array programming and array verify are refused.
// - Security clears by bulk erase, which clears the array too, or by resetn.
// - A 64-bit user signature word is held and reprogrammable.
// - Signature content never affects logic or configuration.
// - Signature is read back through the normal verify command.
// - Signature verify works whether or not secured.
// - Bulk erase clears array, architecture, security and signature.
// - Registered mode: pin A clocks registers, pin B (low) enables their outputs.
// - Other modes: both dedicated pins are plain array inputs.
// - Registered cells use a rising-edge D flip-flop after polarity.
// - Macrocell registers reset low; active-low outputs go high.
module mcs_config_security
  import mcs_pkg::*;
(
  input  wire logic                 sys_clk,
  input  wire logic                 resetn,
  input  wire logic                 cmd_valid,
  input  wire mcs_cmd_type          cmd_code,
  input  wire mcs_sel_type          cmd_sel,
  input  wire logic [ARR_AW-1:0]    cmd_addr,
  input  wire logic [SIG_WIDTH-1:0] cmd_wdata,
  output logic                      rd_valid,
  output logic      [SIG_WIDTH-1:0] rd_data,
  output logic                      cmd_refused,
  output logic                      secured,
  output mcs_mode_type              dev_mode,
  input  wire logic                 ded_pin_a,
  input  wire logic                 ded_pin_b,
  input  wire logic [NUM_CELLS-1:0] sum_term,
  input  wire logic [NUM_CELLS-1:0] oe_term,
  output logic      [NUM_CELLS-1:0] cell_out,
  output logic      [NUM_CELLS-1:0] cell_oe,
  output logic      [NUM_CELLS-1:0] cell_fb,
  output logic      [1:0]           ded_array_in
);

  typedef struct packed {
    logic [ARCH_WIDTH-1:0] arch;
    logic                  secure;
    logic [SIG_WIDTH-1:0]  sig;
    logic                  rd_valid;
    logic [SIG_WIDTH-1:0]  rd_data;
    logic                  refused;
    logic [1:0]            pa_sync;  // Clock pin synchroniser
    logic [1:0]            pb_sync;  // Enable pin synchroniser
  } mcs_top_state_type;

  mcs_top_state_type    st_r;
  mcs_top_state_type    st_nxt;
  // Array store with its write and erase strobes
  logic [ARR_WIDTH-1:0] array_mem [ARR_DEPTH];
  logic                 arr_we;
  logic                 arr_clear;
  logic                 is_cmd;
  logic [ARR_WIDTH-1:0] arr_word;

  // Decoded configuration towards the datapath
  mcs_cfg_if cfg_bus ();

  assign is_cmd = cmd_valid;

  // Addressed array word; only reaches rd_data while unsecured
  assign arr_word = array_mem[cmd_addr];

  // Command decode and configuration state update.
  // Answers are pulses for one cycle; a refused command leaves every
  // stored cell as it was. Only one command per cycle is possible, so
  // erase and set-secure never compete for the security cell.
  always_comb begin
    st_nxt          = st_r;
    st_nxt.rd_valid = 1'b0;
    st_nxt.refused  = 1'b0;
    arr_we          = 1'b0;
    arr_clear       = 1'b0;
    // Pin synchronisers, second stage only feeds logic
    st_nxt.pa_sync  = {st_r.pa_sync[0], ded_pin_a};
    st_nxt.pb_sync  = {st_r.pb_sync[0], ded_pin_b};
    if (is_cmd) begin
      case (cmd_code)
        // Bulk erase: every cell back to blank together
        MCS_CMD_ERASE: begin
          arr_clear     = 1'b1;
          st_nxt.arch   = ARCH_RESET;
          st_nxt.secure = 1'b0;
          st_nxt.sig    = SIG_RESET;
          // Blank device: no earlier read result survives either
          st_nxt.rd_data = SIG_RESET;
        end
        MCS_CMD_WR_ARRAY: begin
          // Locked array refuses writes
          if (st_r.secure) begin
            st_nxt.refused = 1'b1;
          end else begin
            arr_we = 1'b1;
          end
        end
        // Architecture cells are locked together with the array
        MCS_CMD_WR_ARCH: begin
          if (st_r.secure) begin
            st_nxt.refused = 1'b1;
          end else begin
            st_nxt.arch = cmd_wdata[ARCH_WIDTH-1:0];
          end
        end
        MCS_CMD_WR_SIG: begin
          // Signature stays writable; it is not part of the array
          st_nxt.sig = cmd_wdata;
        end
        MCS_CMD_SET_SECURE: begin
          st_nxt.secure  = 1'b1;
          // Drop the last read result, else a secured part would still
          // show array content on rd_data
          st_nxt.rd_data = SIG_RESET;
        end
        MCS_CMD_VERIFY: begin
          case (cmd_sel)
            // Signature answers whatever the security cell holds
            MCS_SEL_SIG: begin
              st_nxt.rd_valid = 1'b1;
              st_nxt.rd_data  = st_r.sig;
            end
            MCS_SEL_ARRAY: begin
              if (st_r.secure) begin
                st_nxt.refused = 1'b1;
              end else begin
                st_nxt.rd_valid = 1'b1;
                st_nxt.rd_data  = {{(SIG_WIDTH-ARR_WIDTH){1'b0}},
                                   arr_word};
              end
            end
            // Architecture read-back is part of the protected pattern
            MCS_SEL_ARCH: begin
              if (st_r.secure) begin
                st_nxt.refused = 1'b1;
              end else begin
                st_nxt.rd_valid = 1'b1;
                st_nxt.rd_data  = {{(SIG_WIDTH-ARCH_WIDTH){1'b0}},
                                   st_r.arch};
              end
            end
            // Reserved verify target
            default: begin
              st_nxt.refused = 1'b1;
            end
          endcase
        end
        // Unknown command code
        default: begin
          st_nxt.refused = 1'b1;
        end
      endcase
    end
  end

  // State register; synchroniser stages reset to constants
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= '{
        arch:     ARCH_RESET,
        secure:   1'b0,
        sig:      SIG_RESET,
        rd_valid: 1'b0,
        rd_data:  SIG_RESET,
        refused:  1'b0,
        pa_sync:  2'h0,
        pb_sync:  2'h0
      };
    end else begin
      st_r <= st_nxt;
    end
  end

  // Array store; no reset, so erase walks every word in one cycle
  always_ff @(posedge sys_clk) begin
    for (int w = 0; w < ARR_DEPTH; w++) begin
      if (arr_clear) begin
        array_mem[w] <= ARR_BLANK;
      end else if (arr_we && cmd_addr == w[ARR_AW-1:0]) begin
        array_mem[w] <= cmd_wdata[ARR_WIDTH-1:0];
      end
    end
  end

  // Only the architecture cells reach the datapath, never the signature
  assign cfg_bus.mode     = mcs_mode_type'(st_r.arch[ARCH_MODE_LSB +: 2]);
  assign cfg_bus.cell_cfg = st_r.arch[ARCH_CELL_LSB +: 2*NUM_CELLS];

  assign rd_valid    = st_r.rd_valid;
  assign rd_data     = st_r.rd_data;
  assign cmd_refused = st_r.refused;
  assign secured     = st_r.secure;
  assign dev_mode    = cfg_bus.mode;

  // Datapath sees only the second synchroniser stage of each pin
  mcs_macrocells u_cells (
    .sys_clk      (sys_clk),
    .resetn       (resetn),
    .cfg          (cfg_bus.cells),
    .ded_pin_a    (st_r.pa_sync[1]),
    .ded_pin_b    (st_r.pb_sync[1]),
    .sum_term     (sum_term),
    .oe_term      (oe_term),
    .cell_out     (cell_out),
    .cell_oe      (cell_oe),
    .cell_fb      (cell_fb),
    .ded_array_in (ded_array_in)
  );

endmodule // mcs_config_security

// ==== logic/mcs_macrocells.sv ====
/*
  Macrocell datapath: per-cell function select, output registers,
  dedicated clock and output-enable pins.
  Assumes synchronised pin inputs and sum terms from the array logic.
*/
`timescale 1ns/1ns
module mcs_macrocells
  import mcs_pkg::*;
(
  input  wire logic                 sys_clk,
  input  wire logic                 resetn,
  mcs_cfg_if.cells                  cfg,
  input  wire logic                 ded_pin_a,
  input  wire logic                 ded_pin_b,
  input  wire logic [NUM_CELLS-1:0] sum_term,
  input  wire logic [NUM_CELLS-1:0] oe_term,
  output logic      [NUM_CELLS-1:0] cell_out,
  output logic      [NUM_CELLS-1:0] cell_oe,
  output logic      [NUM_CELLS-1:0] cell_fb,
  output logic      [1:0]           ded_array_in
);

  typedef struct packed {
    logic [NUM_CELLS-1:0] q;
    logic                 clk_d;
  } mcs_cells_state_type;

  mcs_cells_state_type st_r;
  mcs_cells_state_type st_nxt;
  logic                 clk_rise;
  logic                 reg_mode;
  mcs_func_type         fn [NUM_CELLS];

  assign reg_mode = (cfg.mode == MCS_MODE_REGISTER);
  // Rising edge of the dedicated clock pin, sampled on sys_clk
  assign clk_rise = reg_mode & ded_pin_a & ~st_r.clk_d;
  // Dedicated pins feed the array only outside registered mode
  assign ded_array_in = reg_mode ? 2'h0 : {ded_pin_b, ded_pin_a};

  // Function decode and pin drive per macrocell
  genvar i;
  generate
    for (i = 0; i < NUM_CELLS; i++) begin : g_cell
      logic         b0;
      logic         b1;
      mcs_func_type fn_l;
      logic         out_l;
      logic         oe_l;
      assign b0 = cfg.cell_cfg[2*i];
      assign b1 = cfg.cell_cfg[2*i+1];
      always_comb begin
        case (cfg.mode)
          MCS_MODE_SIMPLE:   fn_l = b0 ? MCS_FN_INPUT : MCS_FN_OUTPUT;
          MCS_MODE_REGISTER: fn_l = b0 ? MCS_FN_IO : MCS_FN_REG;
          MCS_MODE_MEDIUM:   fn_l = (i == CELL_LOW || i == CELL_HIGH) ?
                                    MCS_FN_TRISTAT : MCS_FN_IO;
          default:           fn_l = MCS_FN_INPUT;
        endcase
      end
      always_comb begin
        case (fn_l)
          MCS_FN_OUTPUT: begin
            out_l = sum_term[i] ^ b1;
            oe_l  = 1'b1;
          end
          MCS_FN_REG: begin
            out_l = ~st_r.q[i];  // Registers drive active low
            oe_l  = ~ded_pin_b;
          end
          MCS_FN_IO, MCS_FN_TRISTAT: begin
            out_l = sum_term[i] ^ b1;
            oe_l  = oe_term[i];
          end
          default: begin
            out_l = 1'b0;
            oe_l  = 1'b0;
          end
        endcase
      end
      // One continuous driver per bit keeps each vector single-driven
      assign fn[i]       = fn_l;
      assign cell_out[i] = out_l;
      assign cell_oe[i]  = oe_l;
      assign cell_fb[i]  = st_r.q[i];
    end
  endgenerate

  // Polarity applied before the register; load on clock pin rise
  always_comb begin
    st_nxt       = st_r;
    st_nxt.clk_d = ded_pin_a;
    for (int k = 0; k < NUM_CELLS; k++) begin
      if (clk_rise && fn[k] == MCS_FN_REG) begin
        st_nxt.q[k] = sum_term[k] ^ cfg.cell_cfg[2*k+1];
      end
    end
  end

  // Registers come up low after reset
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= '{q: REG_RESET, clk_d: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule // mcs_macrocells

// ==== logic/mcs_pkg.sv ====
/*
  Shared constants and types for the macrocell configuration and
  security block: cell widths, mode and function encodings, commands.
  Assumes a single 100 MHz clock domain.
*/
package mcs_pkg;

  localparam int NUM_CELLS = 8;   // Output macrocells
  localparam int SIG_WIDTH = 64;  // User signature word
  localparam int ARR_WIDTH = 32;  // Array word width on the program port
  localparam int ARR_DEPTH = 64;  // Array words held
  localparam int ARR_AW    = 6;

  // Architecture cell layout: [1:0] mode, then two bits per macrocell
  localparam int ARCH_MODE_LSB = 0;
  localparam int ARCH_CELL_LSB = 2;
  localparam int ARCH_WIDTH    = 2 + 2 * NUM_CELLS;
  localparam logic [ARCH_WIDTH-1:0] ARCH_RESET = 18'h00000;
  localparam logic [SIG_WIDTH-1:0]  SIG_RESET  = 64'h0000000000000000;
  localparam logic [ARR_WIDTH-1:0]  ARR_BLANK  = 32'h00000000;
  localparam logic [NUM_CELLS-1:0]  REG_RESET  = 8'h00;

  // Indices of the two outermost macrocells
  localparam int CELL_LOW  = 0;
  localparam int CELL_HIGH = NUM_CELLS - 1;

  typedef enum logic [1:0] {
    MCS_MODE_SIMPLE   = 2'h0,
    MCS_MODE_REGISTER = 2'h1,
    MCS_MODE_MEDIUM   = 2'h2,
    MCS_MODE_RSVD     = 2'h3
  } mcs_mode_type;

  // Per-macrocell function as decoded
  typedef enum logic [2:0] {
    MCS_FN_INPUT   = 3'h0,
    MCS_FN_OUTPUT  = 3'h1,
    MCS_FN_REG     = 3'h2,
    MCS_FN_IO      = 3'h3,
    MCS_FN_TRISTAT = 3'h4
  } mcs_func_type;

  typedef enum logic [2:0] {
    MCS_CMD_NONE       = 3'h0,
    MCS_CMD_ERASE      = 3'h1,
    MCS_CMD_WR_ARRAY   = 3'h2,
    MCS_CMD_WR_ARCH    = 3'h3,
    MCS_CMD_WR_SIG     = 3'h4,
    MCS_CMD_SET_SECURE = 3'h5,
    MCS_CMD_VERIFY     = 3'h6
  } mcs_cmd_type;

  // Verify targets
  typedef enum logic [1:0] {
    MCS_SEL_ARRAY = 2'h0,
    MCS_SEL_ARCH  = 2'h1,
    MCS_SEL_SIG   = 2'h2,
    MCS_SEL_RSVD  = 2'h3
  } mcs_sel_type;

endpackage

// ==== verification/mcs_config_security_asserts.sv ====
/* Concurrent checks on the configuration and security block ports.
   Assumes the bind below and a single sys_clk domain. */
`timescale 1ns/1ns
module mcs_cfg_sec_asserts
  import mcs_pkg::*;
(
  input wire logic              sys_clk,
  input wire logic              resetn,
  input wire logic              cmd_valid,
  input wire mcs_cmd_type       cmd_code,
  input wire mcs_sel_type       cmd_sel,
  input wire logic              rd_valid,
  input wire logic              cmd_refused,
  input wire logic              secured,
  input wire mcs_mode_type      dev_mode,
  input wire logic [NUM_CELLS-1:0] oe_term,
  input wire logic [NUM_CELLS-1:0] cell_oe,
  input wire logic [NUM_CELLS-1:0] cell_fb,
  input wire logic [1:0]        ded_array_in
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // Decoded command strobes
  wire era  = cmd_valid && cmd_code == MCS_CMD_ERASE;
  wire warr = cmd_valid && cmd_code == MCS_CMD_WR_ARRAY;
  wire warch = cmd_valid && cmd_code == MCS_CMD_WR_ARCH;
  wire wsec  = cmd_valid && cmd_code == MCS_CMD_SET_SECURE;
  wire vcmd  = cmd_valid && cmd_code == MCS_CMD_VERIFY;
  wire varr  = vcmd && cmd_sel == MCS_SEL_ARRAY;
  wire vsig  = vcmd && cmd_sel == MCS_SEL_SIG;
  chk_arch_lock:
    assert property (secured && warch |=> cmd_refused && $stable(dev_mode))
      else $error("architecture write not refused while secured");
  chk_sec_set:
    assert property (wsec |=> secured)
      else $error("security cell not set");
  chk_arr_wr_lock:
    assert property (secured && warr |=> cmd_refused && !rd_valid)
      else $error("array write not refused while secured");
  chk_arr_rd_lock:
    assert property (secured && varr |=> cmd_refused && !rd_valid)
      else $error("array verify not refused while secured");
  chk_sec_hold:
    assert property (secured && !era |=> secured)
      else $error("security cleared without erase");
  chk_erase_blank:
    assert property (era |=> !secured && dev_mode == MCS_MODE_SIMPLE)
      else $error("erase left state behind");
  chk_sig_read:
    assert property (vsig |=> rd_valid && !cmd_refused)
      else $error("signature verify not answered");
  chk_sig_inert:
    assert property (cmd_valid && cmd_code == MCS_CMD_WR_SIG
                     |=> $stable(dev_mode) && $stable(secured))
      else $error("signature write changed configuration");
  chk_reg_pins:
    assert property (dev_mode == MCS_MODE_REGISTER && $stable(dev_mode)
                     |-> ded_array_in == 2'h0)
      else $error("dedicated pins reach array in registered mode");
  chk_medium_oe:
    assert property (dev_mode == MCS_MODE_MEDIUM |-> cell_oe == oe_term)
      else $error("medium mode enables not from array");
  chk_fb_reset:
    assert property ($rose(resetn) |-> cell_fb == REG_RESET)
      else $error("macrocell registers not low after reset");
  // Main scenarios reached
  cover property (secured && warr);
  cover property (secured && vsig);
  cover property (dev_mode == MCS_MODE_REGISTER && cell_fb != 8'h00);
endmodule // mcs_cfg_sec_asserts

bind mcs_config_security mcs_cfg_sec_asserts u_chk (
  .sys_clk, .resetn, .cmd_valid, .cmd_code, .cmd_sel, .rd_valid,
  .cmd_refused, .secured, .dev_mode, .oe_term, .cell_oe, .cell_fb,
  .ded_array_in);

// ==== verification/mcs_config_security_tb.sv ====
/* Self-checking bench for the configuration and security block.
   Assumes the programmer model drives the command port. */
`timescale 1ns/1ns
module mcs_config_security_tb;
  import mcs_pkg::*;
  logic sys_clk, resetn, cmd_valid, rd_valid, cmd_refused, secured;
  logic ded_pin_a, ded_pin_b;
  mcs_cmd_type cmd_code;
  mcs_sel_type cmd_sel;
  mcs_mode_type dev_mode;
  logic [ARR_AW-1:0] cmd_addr;
  logic [SIG_WIDTH-1:0] cmd_wdata, rd_data;
  logic [NUM_CELLS-1:0] sum_term, oe_term, cell_out, cell_oe, cell_fb;
  logic [1:0] ded_array_in;
  int err_total, cmp_count;
  mcs_prog_model u_prog (.sys_clk, .cmd_valid, .cmd_code, .cmd_sel,
    .cmd_addr, .cmd_wdata, .rd_valid, .rd_data, .cmd_refused);
  mcs_config_security u_dut (.sys_clk, .resetn, .cmd_valid, .cmd_code,
    .cmd_sel, .cmd_addr, .cmd_wdata, .rd_valid, .rd_data, .cmd_refused,
    .secured, .dev_mode, .ded_pin_a, .ded_pin_b, .sum_term, .oe_term,
    .cell_out, .cell_oe, .cell_fb, .ded_array_in);
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic check(input string what, input logic [63:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Blank device: simple mode, every cell an active output
  task automatic t_reset();
    check("mode", dev_mode, MCS_MODE_SIMPLE);
    check("oe", cell_oe, 8'hff);
    check("fb", cell_fb, 8'h00);
  endtask
  // Lock, refusals, signature still readable, erase unlocks
  task automatic t_secure();
    u_prog.prog_pass(18'h00000, 64'h0123456789abcdef);
    u_prog.issue(MCS_CMD_WR_ARRAY, MCS_SEL_ARRAY, 6'h3f, 64'ha5c3e1f7);
    u_prog.issue(MCS_CMD_VERIFY, MCS_SEL_ARRAY, 6'h3f, 64'h0);
    check("arr", u_prog.ans_data, 64'ha5c3e1f7);
    u_prog.issue(MCS_CMD_VERIFY, MCS_SEL_SIG, 6'h00, 64'h0);
    check("sig", u_prog.ans_data, 64'h0123456789abcdef);
    u_prog.issue(MCS_CMD_SET_SECURE, MCS_SEL_ARRAY, 6'h00, 64'h0);
    check("sec", secured, 1'b1);
    check("rd clr", rd_data, 64'h0);
    u_prog.issue(MCS_CMD_WR_ARRAY, MCS_SEL_ARRAY, 6'h3f, 64'h0);
    check("wr ref", {u_prog.ans_ref, u_prog.ans_rd}, 2'h2);
    u_prog.issue(MCS_CMD_VERIFY, MCS_SEL_ARRAY, 6'h3f, 64'h0);
    check("arr ref", {u_prog.ans_ref, u_prog.ans_rd}, 2'h2);
    u_prog.issue(MCS_CMD_WR_ARCH, MCS_SEL_ARRAY, 6'h00, 64'h2);
    check("arch ref", u_prog.ans_ref, 1'b1);
    check("mode", dev_mode, MCS_MODE_SIMPLE);
    u_prog.issue(MCS_CMD_WR_SIG, MCS_SEL_ARRAY, 6'h00, 64'hfeed);
    u_prog.issue(MCS_CMD_VERIFY, MCS_SEL_SIG, 6'h00, 64'h0);
    check("sig sec", u_prog.ans_data, 64'hfeed);
    u_prog.issue(MCS_CMD_ERASE, MCS_SEL_ARRAY, 6'h00, 64'h0);
    check("unsec", secured, 1'b0);
    u_prog.issue(MCS_CMD_VERIFY, MCS_SEL_ARRAY, 6'h3f, 64'h0);
    check("arr blank", u_prog.ans_data, 64'h0);
    u_prog.issue(MCS_CMD_VERIFY, MCS_SEL_SIG, 6'h00, 64'h0);
    check("sig blank", u_prog.ans_data, 64'h0);
  endtask
  // Medium mode: enables follow array, pins feed the array
  task automatic t_medium();
    u_prog.prog_pass(18'h00002, 64'h5555);
    oe_term   = 8'h5a;
    ded_pin_a = 1'b1;
    cyc(5);
    check("med oe", cell_oe, 8'h5a);
    check("pins", ded_array_in, 2'h1);
    // Simple mode: cell 0 inverted output, cell 1 input; then reserved
    sum_term = 8'h0f;
    u_prog.prog_pass(18'h00018, 64'h0);
    check("smp oe", cell_oe, 8'hfd);
    check("smp out", cell_out, 8'h0c);
    check("smp pins", ded_array_in, 2'h1);
    u_prog.prog_pass(18'h00003, 64'h0);
    check("rsv oe", cell_oe, 8'h00);
    check("rsv out", cell_out, 8'h00);
  endtask
  // Registered mode: pin A clocks, pin B gates, polarity before flop
  task automatic t_registered();
    u_prog.prog_pass(18'h00001, 64'h0);
    ded_pin_a = 1'b0;
    sum_term  = 8'h96;
    cyc(5);
    check("no clk", cell_fb, 8'h00);
    ded_pin_a = 1'b1;
    cyc(5);
    check("fb", cell_fb, 8'h96);
    check("out", cell_out, 8'h69);
    check("oe on", cell_oe, 8'hff);
    check("pins", ded_array_in, 2'h0);
    ded_pin_b = 1'b1;
    cyc(5);
    check("oe off", cell_oe, 8'h00);
    u_prog.prog_pass(18'h2aaa9, 64'h0);
    ded_pin_a = 1'b0;
    cyc(5);
    ded_pin_a = 1'b1;
    cyc(5);
    check("pol", cell_fb, 8'h69);
    resetn = 1'b0;
    cyc(2);
    resetn = 1'b1;
    check("rst fb", cell_fb, 8'h00);
    // Registered again with no clock edge: low registers drive high
    ded_pin_b = 1'b0;
    u_prog.prog_pass(18'h00001, 64'h0);
    check("rst out", cell_out, 8'hff);
    check("rst oe", cell_oe, 8'hff);
  endtask
  initial begin
    #200000;
    err_total++;
    end_sim();
  end
  initial begin
    resetn    = 1'b0;
    ded_pin_a = 1'b0;
    ded_pin_b = 1'b0;
    sum_term  = 8'h00;
    oe_term   = 8'h00;
    cyc(3);
    resetn = 1'b1;
    t_reset();
    t_secure();
    t_medium();
    t_registered();
    end_sim();
  end
endmodule // mcs_config_security_tb

// ==== verification/mcs_prog_model.sv ====
/* Model of the programming equipment on the command port.
   Assumes answers come one cycle after the taking edge. */
`timescale 1ns/1ns
module mcs_prog_model
  import mcs_pkg::*;
(
  input  wire logic                 sys_clk,
  output logic                      cmd_valid,
  output mcs_cmd_type               cmd_code,
  output mcs_sel_type               cmd_sel,
  output logic      [ARR_AW-1:0]    cmd_addr,
  output logic      [SIG_WIDTH-1:0] cmd_wdata,
  input  wire logic                 rd_valid,
  input  wire logic [SIG_WIDTH-1:0] rd_data,
  input  wire logic                 cmd_refused
);
  logic                 ans_rd;
  logic                 ans_ref;
  logic [SIG_WIDTH-1:0] ans_data;
  initial begin
    cmd_valid = 1'b0;
    cmd_code  = MCS_CMD_NONE;
    cmd_sel   = MCS_SEL_ARRAY;
    cmd_addr  = 6'h00;
    cmd_wdata = 64'h0;
  end
  // One command; idle data inverted so stale values never look valid
  task automatic issue(input mcs_cmd_type c, input mcs_sel_type s,
                       input logic [ARR_AW-1:0] a,
                       input logic [SIG_WIDTH-1:0] d);
    @(posedge sys_clk);
    #1;
    cmd_valid = 1'b1;
    cmd_code  = c;
    cmd_sel   = s;
    cmd_addr  = a;
    cmd_wdata = d;
    @(posedge sys_clk);
    #1;
    cmd_valid = 1'b0;
    cmd_addr  = ~a;
    cmd_wdata = ~d;
    ans_rd    = rd_valid;
    ans_ref   = cmd_refused;
    ans_data  = rd_data;
  endtask
  // Programming pass of architecture and signature, always preceded by a bulk erase
  task automatic prog_pass(input logic [ARCH_WIDTH-1:0] arch,
                         input logic [SIG_WIDTH-1:0] sig);
    issue(MCS_CMD_ERASE, MCS_SEL_ARRAY, 6'h00, 64'h0);
    issue(MCS_CMD_WR_ARCH, MCS_SEL_ARRAY, 6'h00, {46'h0, arch});
    issue(MCS_CMD_WR_SIG, MCS_SEL_ARRAY, 6'h00, sig);
  endtask
endmodule // mcs_prog_model
